// ### design/pio_irq_out.sv
// Purpose : Interrupt request output logic for serial, parallel and floppy sources
// Assumes : Sources and pins are asynchronous and pass two flip-flops first
// Notes   : All pin outputs and enables are registered
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/10ps

// Overview of operation
// - Second/fourth serial ports drive line three
// - Serial irq needs enable, gate, condition
// - Serial irq clears on disable; service ignored
// - Serial output floats when gate bit low
// - Parallel irq follows acknowledge when enabled
// - Parallel enable needs control bit, address
// - Parallel pin bidirectional only ECP configured
// - Floppy irq on completion or transfer ready
// - Floppy gated by D3 except second mode
// - Encoding pin sampled at reset selects mode
// - Master reset clears control registers
// - Encoding pin floats during chip reset, then format
// - Both straps high select first mode
module pio_irq_out (
    input  wire logic                 SYS_CLK,
    input  wire logic                 RESETN,
    input  wire logic                 CLK_EN,
    input  wire logic                 MASTER_RESET_IN,
    input  wire logic                 CHIP_RESET,
    input  wire logic                 IDENT_STRAP,
    input  wire logic                 ENC_PIN_I,
    input  wire logic [1:0][3:0]      SER_COND,
    input  wire logic [1:0]           SER_SERVICED,
    input  wire logic                 PRN_ACK,
    input  wire logic                 FDC_DONE,
    input  wire logic                 FDC_XFER_RDY,
    input  wire logic                 IRQ5_I,
    input  wire logic                 IRQ7_I,
    input  wire pio_pkg::pio_avm_req_s AVM_REQ,
    output logic [31:0]               AVM_READDATA,
    output logic                      AVM_WAITREQUEST,
    output pio_pkg::pio_pin_s         IRQ3_PIN,
    output pio_pkg::pio_pin_s         IRQ4_PIN,
    output pio_pkg::pio_pin_s         IRQ5_PIN,
    output pio_pkg::pio_pin_s         IRQ6_PIN,
    output pio_pkg::pio_pin_s         IRQ7_PIN,
    output logic                      IRQ5_DIR_IN,
    output logic                      IRQ7_DIR_IN,
    output pio_pkg::pio_pin_s         ENC_PIN,
    output pio_pkg::pio_mode_e        COMPAT_MODE
);
    import pio_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Only the second stage feeds logic; the first may go metastable
    localparam int NS = 19;
    logic [NS-1:0] in_raw;
    logic [NS-1:0] sy1_q;
    logic [NS-1:0] sy2_q;

    assign in_raw = {MASTER_RESET_IN, CHIP_RESET, IDENT_STRAP, ENC_PIN_I, SER_COND,
                     SER_SERVICED, PRN_ACK, FDC_DONE, FDC_XFER_RDY, IRQ5_I, IRQ7_I};

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            sy1_q <= '0;
            sy2_q <= '0;
        end else if (CLK_EN) begin
            sy1_q <= in_raw;
            sy2_q <= sy1_q;
        end
    end

    wire       mr_s      = sy2_q[18];
    wire       crst_s    = sy2_q[17];
    wire       ident_s   = sy2_q[16];
    wire       enc_s     = sy2_q[15];
    wire [3:0] cond0_s   = sy2_q[10:7];
    wire [3:0] cond1_s   = sy2_q[14:11];
    wire [1:0] svc_s     = sy2_q[6:5];
    wire       ack_s     = sy2_q[4];
    wire       fdone_s   = sy2_q[3];
    wire       fxrdy_s   = sy2_q[2];

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic [7:0] ser0_q, ser1_q, par_q, fdc_q;
    logic       wait_q;
    logic       enc_q;
    logic [31:0] rdata_q;

    wire        req_any  = AVM_REQ.read | AVM_REQ.write;
    wire        acc_done = req_any & !wait_q;
    wire        wr_go    = acc_done & AVM_REQ.write;
    wire        hit_s0   = AVM_REQ.address == PIO_OFF_SER0;
    wire        hit_s1   = AVM_REQ.address == PIO_OFF_SER1;
    wire        hit_pa   = AVM_REQ.address == PIO_OFF_PAR;
    wire        hit_fd   = AVM_REQ.address == PIO_OFF_FDC;
    wire [7:0]  wbyte    = AVM_REQ.writedata[7:0];
    logic [7:0] rsel;

    always_comb begin
        rsel = 8'h00;
        unique case (1'b1)
            hit_s0: rsel = ser0_q;
            hit_s1: rsel = ser1_q;
            hit_pa: rsel = par_q;
            hit_fd: rsel = {fdc_q[7:5], enc_q, fdc_q[3:0]};
            default: rsel = 8'h00;
        endcase
    end

    // Wait exactly one cycle, then answer
    // Idles high, so no access can complete unseen
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else if (CLK_EN) begin
            wait_q  <= !(req_any & wait_q);
            if (req_any & wait_q) rdata_q <= {24'h0, rsel};
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            ser0_q <= PIO_RST_SER;
            ser1_q <= PIO_RST_SER;
            par_q  <= PIO_RST_PAR;
            fdc_q  <= PIO_RST_FDC;
        end else if (CLK_EN) begin
            if (mr_s) begin
                ser0_q <= PIO_RST_SER;
                ser1_q <= PIO_RST_SER;
                par_q  <= PIO_RST_PAR;
                fdc_q  <= PIO_RST_FDC;
            end else if (wr_go) begin
                if (hit_s0) ser0_q <= wbyte;
                if (hit_s1) ser1_q <= wbyte;
                if (hit_pa) par_q  <= wbyte;
                if (hit_fd) fdc_q  <= wbyte;
            end
        end
    end

    // ----------------------------------------------------------------
    // Serial interrupts
    // ----------------------------------------------------------------
    function automatic logic ser_req(input logic [7:0] r, input logic [3:0] c);
        return |(r[3:0] & c) & r[PIO_SER_MODEM_CTRL_IRQ_GATE_BIT_BIT];
    endfunction

    function automatic logic on_line3(input logic [7:0] r);
        pio_com_e d;
        d = pio_com_e'(r[PIO_SER_DES_LSB +: 2]);
        return (d == PIO_COM_SECOND) || (d == PIO_COM_FOURTH);
    endfunction

    logic [1:0] sirq_q;
    wire  [1:0] s_set = {ser_req(ser1_q, cond1_s), ser_req(ser0_q, cond0_s)};
    // Request follows set each cycle; service has no effect
    wire  [1:0] s_nxt = s_set | (sirq_q & ~svc_s & s_set);

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) sirq_q <= 2'b00;
        else if (CLK_EN) sirq_q <= mr_s ? 2'b00 : s_nxt;
    end

    wire l3_0 = on_line3(ser0_q);
    wire l3_1 = on_line3(ser1_q);
    wire g0   = ser0_q[PIO_SER_MODEM_CTRL_IRQ_GATE_BIT_BIT];
    wire g1   = ser1_q[PIO_SER_MODEM_CTRL_IRQ_GATE_BIT_BIT];
    wire i3_oe = (l3_0 & g0) | (l3_1 & g1);
    wire i4_oe = (!l3_0 & g0) | (!l3_1 & g1);
    wire i3_o  = (l3_0 & g0 & sirq_q[0]) | (l3_1 & g1 & sirq_q[1]);
    wire i4_o  = (!l3_0 & g0 & sirq_q[0]) | (!l3_1 & g1 & sirq_q[1]);

    // ----------------------------------------------------------------
    // Parallel and floppy
    // ----------------------------------------------------------------
    // Control bit and address
    wire p_en  = par_q[PIO_PAR_EN_BIT] & par_q[PIO_PAR_ADR_BIT];
    wire p_dir = par_q[PIO_PAR_ECP_BIT] & par_q[PIO_PAR_CFG_BIT];

    // Mode from straps at chip reset
    pio_mode_e mode_q;
    wire pio_mode_e mode_d = ident_s ? (enc_s ? PIO_MODE_FIRST : PIO_MODE_ILLEGAL)
                                     : (enc_s ? PIO_MODE_SECOND : PIO_MODE_THIRD);
    wire f_gate = (mode_q == PIO_MODE_SECOND) | fdc_q[PIO_FDC_D3_BIT];

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_q <= PIO_MODE_FIRST;
            enc_q  <= 1'b0;
        end else if (CLK_EN) begin
            if (crst_s) mode_q <= mode_d;
            enc_q <= crst_s ? 1'b0 : fdc_q[PIO_FDC_ENC_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Output registers
    // ----------------------------------------------------------------
    // Registered pin outputs
    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            IRQ3_PIN    <= '0;
            IRQ4_PIN    <= '0;
            IRQ5_PIN    <= '0;
            IRQ6_PIN    <= '0;
            IRQ7_PIN    <= '0;
            IRQ5_DIR_IN <= 1'b0;
            IRQ7_DIR_IN <= 1'b0;
            ENC_PIN     <= '0;
        end else if (CLK_EN) begin
            IRQ3_PIN    <= '{o: i3_o, oe: i3_oe};
            IRQ4_PIN    <= '{o: i4_o, oe: i4_oe};
            IRQ5_PIN    <= '{o: p_en & ack_s, oe: p_en & !p_dir};
            IRQ7_PIN    <= '{o: p_en & ack_s, oe: p_en & !p_dir};
            IRQ5_DIR_IN <= p_dir;
            IRQ7_DIR_IN <= p_dir;
            IRQ6_PIN    <= '{o: (fdone_s | fxrdy_s) & f_gate, oe: 1'b1};
            ENC_PIN     <= '{o: enc_q, oe: !crst_s};
        end
    end

    assign AVM_READDATA    = rdata_q;
    assign AVM_WAITREQUEST = wait_q;
    assign COMPAT_MODE     = mode_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);

    ser_float_a: assert property (CLK_EN && !g0 && !g1 |=> !IRQ3_PIN.oe && !IRQ4_PIN.oe)
        else $error("Serial line driven with gate low");
    ser_route_a: assert property (CLK_EN && g0 && !g1 && l3_0 |=> !IRQ4_PIN.oe)
        else $error("Serial routed to wrong line");
    ser_set_a: assert property (CLK_EN && !mr_s && s_set[0] |=> sirq_q[0])
        else $error("Serial request not raised");
    ser_clr_a: assert property (CLK_EN && !s_set[0] |=> !sirq_q[0])
        else $error("Serial request not cleared");
    par_float_a: assert property (CLK_EN && !p_en |=> !IRQ5_PIN.oe && !IRQ5_PIN.o)
        else $error("Parallel line driven while disabled");
    par_follow_a: assert property (CLK_EN && p_en && !p_dir |=> IRQ7_PIN.o == $past(ack_s))
        else $error("Parallel line not following ack");
    par_dir_a: assert property (CLK_EN && !p_dir |=> !IRQ5_DIR_IN)
        else $error("Parallel pin input outside ECP");
    fdc_gate_a: assert property (CLK_EN && mode_q == PIO_MODE_THIRD && !f_gate |=> !IRQ6_PIN.o)
        else $error("Floppy irq not gated");
    mr_clear_a: assert property (CLK_EN && mr_s |=> fdc_q == PIO_RST_FDC && sirq_q == 2'b00)
        else $error("Master reset left state");
    enc_low_a: assert property (CLK_EN && crst_s |=> !enc_q)
        else $error("Encoding pin not low at reset");
    fdc_irq_a: assert property (CLK_EN && (fdone_s || fxrdy_s) && f_gate |=> IRQ6_PIN.o)
        else $error("Floppy irq not raised");
    fdc_second_a: assert property (
        CLK_EN && mode_q == PIO_MODE_SECOND && fdone_s |=> IRQ6_PIN.o)
        else $error("Floppy irq gated in second mode");
    mode_second_a: assert property (
        CLK_EN && crst_s && !ident_s && enc_s |=> mode_q == PIO_MODE_SECOND)
        else $error("Second mode not latched");
    mode_third_a: assert property (
        CLK_EN && crst_s && !ident_s && !enc_s |=> mode_q == PIO_MODE_THIRD)
        else $error("Third mode not latched");
    mode_first_a: assert property (
        CLK_EN && crst_s && ident_s && enc_s |=> mode_q == PIO_MODE_FIRST)
        else $error("First mode not latched");
    enc_float_a: assert property (CLK_EN && crst_s |=> !ENC_PIN.oe)
        else $error("Encoding pin driven during strap read");
    enc_fmt_a: assert property (
        CLK_EN && !crst_s |=> enc_q == $past(fdc_q[PIO_FDC_ENC_BIT]))
        else $error("Encoding pin not showing format");
    wait_one_a: assert property (CLK_EN && req_any && wait_q |=> !AVM_WAITREQUEST)
        else $error("Access not answered");
    wait_back_a: assert property (CLK_EN && !wait_q |=> AVM_WAITREQUEST)
        else $error("Waitrequest low too long");
    ser_line3_a: assert property (
        CLK_EN && g0 && !g1 && l3_0 |=> IRQ3_PIN.oe && IRQ3_PIN.o == $past(sirq_q[0]))
        else $error("Serial not on line three");
    par_dir_on_a: assert property (CLK_EN && p_dir |=> IRQ7_DIR_IN && !IRQ7_PIN.oe)
        else $error("Parallel pin not turned to input");
    mr_regs_a: assert property (
        CLK_EN && mr_s |=> ser0_q == PIO_RST_SER && par_q == PIO_RST_PAR)
        else $error("Master reset left control registers");
    ser_off_a: assert property (CLK_EN && ser0_q[3:0] == 4'h0 |=> !sirq_q[0])
        else $error("Disabled serial source still requests");
    unmapped_zero_a: assert property (
        CLK_EN && req_any && wait_q && !(hit_s0 || hit_s1 || hit_pa || hit_fd)
        |=> AVM_READDATA == 32'h0) else $error("Unmapped read not zero");
    par_five_a: assert property (
        CLK_EN && p_en && !p_dir |=> IRQ5_PIN.oe && IRQ5_PIN.o == $past(ack_s))
        else $error("Parallel line five not following ack");

    // ----------------------------------------------------------------
    // Cover points
    // ----------------------------------------------------------------
    cov_ser_c: cover property (IRQ3_PIN.o ##1 !IRQ3_PIN.o);
    cov_par_c: cover property (IRQ5_PIN.oe && IRQ5_PIN.o);
    cov_fdc_c: cover property (mode_q == PIO_MODE_SECOND && IRQ6_PIN.o);
    cov_mode_c: cover property (crst_s ##1 mode_q == PIO_MODE_THIRD);
    cov_dir_c: cover property (IRQ7_DIR_IN && p_en);
endmodule

// ### design/pio_pkg.sv
// Purpose : Shared constants and carrier types for the interrupt output logic
// Assumes : One system clock, Avalon-MM register access, 32-bit data
// Notes   : Offsets are byte addresses of aligned words
package pio_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] PIO_OFF_SER0   = 4'h0;
    localparam logic [3:0] PIO_OFF_SER1   = 4'h4;
    localparam logic [3:0] PIO_OFF_PAR    = 4'h8;
    localparam logic [3:0] PIO_OFF_FDC    = 4'hC;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    // Serial: [3:0] enable mask, [4] modem gate bit, [6:5] port designation
    localparam int PIO_SER_MODEM_CTRL_IRQ_GATE_BIT_BIT  = 4;
    localparam int PIO_SER_DES_LSB   = 5;
    // Parallel: [4] control bit 4, [5] address match, [6] ecp enable, [7] line configured
    localparam int PIO_PAR_EN_BIT    = 4;
    localparam int PIO_PAR_ADR_BIT   = 5;
    localparam int PIO_PAR_ECP_BIT   = 6;
    localparam int PIO_PAR_CFG_BIT   = 7;
    // Floppy: [3] output register gate bit, [4] encoding format
    localparam int PIO_FDC_D3_BIT    = 3;
    localparam int PIO_FDC_ENC_BIT   = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PIO_RST_SER   = 8'h00;
    localparam logic [7:0] PIO_RST_PAR   = 8'h00;
    localparam logic [7:0] PIO_RST_FDC   = 8'h00;
    localparam logic [1:0] PIO_BUS_WAIT  = 2'h1;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        PIO_COM_FIRST,
        PIO_COM_SECOND,
        PIO_COM_THIRD,
        PIO_COM_FOURTH
    } pio_com_e;

    typedef enum logic [1:0] {
        PIO_MODE_FIRST,
        PIO_MODE_SECOND,
        PIO_MODE_THIRD,
        PIO_MODE_ILLEGAL
    } pio_mode_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [3:0]  address;
        logic [31:0] writedata;
    } pio_avm_req_s;

    typedef struct packed {
        logic        o;
        logic        oe;
    } pio_pin_s;

endpackage

// ### tb/pio_host_pic.sv
// Purpose: host interrupt controller model on the request lines
// Assumes: one system clock
// Notes: an undriven line toggles so a float never reads stable
`timescale 1ns/10ps
module pio_host_pic (
    input  wire logic              sys_clk,
    input  wire pio_pkg::pio_pin_s pin_3,
    input  wire pio_pkg::pio_pin_s pin_4,
    input  wire pio_pkg::pio_pin_s pin_5,
    input  wire pio_pkg::pio_pin_s pin_6,
    input  wire pio_pkg::pio_pin_s pin_7,
    output logic [7:3]             lvl
);
    import pio_pkg::*;
    pio_pin_s p [7:3];
    assign p[3] = pin_3;
    assign p[4] = pin_4;
    assign p[5] = pin_5;
    assign p[6] = pin_6;
    assign p[7] = pin_7;
    initial lvl = 5'h00;
    always @(posedge sys_clk) begin
        for (int i = 3; i < 8; i++) begin
            lvl[i] <= p[i].oe ? p[i].o : ~lvl[i];
        end
    end
endmodule

// ### tb/peripheral_irq_output_logic_test.sv
// Purpose: self-checking bench of the interrupt output logic
// Assumes: fixed seed, Avalon master held until waitrequest low
// Notes: outputs settle within 4 edges of an input; bench waits 6
`timescale 1ns/10ps
module peripheral_irq_output_logic_test;
    import pio_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, mr = 1'b0, crst = 1'b0, ident = 1'b1, enc_i = 1'b1;
    logic [1:0][3:0] cond = '0;
    logic [1:0] svc = '0;
    logic ack = 1'b0, done = 1'b0, xrdy = 1'b0;
    pio_avm_req_s req = '0;
    logic [31:0] rdata, q, r;
    logic wreq, d5, d7;
    pio_pin_s p3, p4, p5, p6, p7, encp;
    pio_mode_e mode;
    logic [7:3] lvl;
    logic [31:0] seed = 32'h8503CBE5;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    pio_irq_out pio_irq_out_inst (.SYS_CLK(clk), .RESETN(rstn), .CLK_EN(1'b1),
        .MASTER_RESET_IN(mr), .CHIP_RESET(crst), .IDENT_STRAP(ident), .ENC_PIN_I(enc_i),
        .SER_COND(cond), .SER_SERVICED(svc), .PRN_ACK(ack), .FDC_DONE(done),
        .FDC_XFER_RDY(xrdy), .IRQ5_I(lvl[5]), .IRQ7_I(lvl[7]), .AVM_REQ(req),
        .AVM_READDATA(rdata), .AVM_WAITREQUEST(wreq), .IRQ3_PIN(p3), .IRQ4_PIN(p4),
        .IRQ5_PIN(p5), .IRQ6_PIN(p6), .IRQ7_PIN(p7), .IRQ5_DIR_IN(d5),
        .IRQ7_DIR_IN(d7), .ENC_PIN(encp), .COMPAT_MODE(mode));
    pio_host_pic pio_host_pic_inst (.sys_clk(clk), .pin_3(p3), .pin_4(p4),
        .pin_5(p5), .pin_6(p6), .pin_7(p7), .lvl(lvl));
    initial begin
        forever #20 clk = ~clk;
    end
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [1:0] ser_exp(logic [6:0] rg, logic [3:0] c);
        return {rg[4], rg[4] & |(rg[3:0] & c)};
    endfunction
    function automatic pio_mode_e mode_exp(int k);
        case (k)
            3: return PIO_MODE_FIRST;
            2: return PIO_MODE_ILLEGAL;
            1: return PIO_MODE_SECOND;
            default: return PIO_MODE_THIRD;
        endcase
    endfunction
    task automatic end_of_test;
        if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        req <= '{~wr, wr, a, d};
        @(posedge clk);
        while (wreq !== 1'b0) @(posedge clk);
        q = rdata;
        req <= '0;
        @(posedge clk);
    endtask
    task automatic settle;
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ----
    // Scenarios
    // ----
    initial begin
        repeat (12) @(posedge clk);
        chk("rst_oe", {p3.oe, p4.oe, p5.oe, p7.oe, wreq}, 5'h01);
        chk("rst_mode", mode, PIO_MODE_FIRST);
        rstn <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            crst <= 1'b1;
            ident <= k[1];
            enc_i <= k[0];
            settle();
            chk("enc_rd", encp.oe, 1'b0);
            crst <= 1'b0;
            // Board keeps the strap pin pulled high
            ident <= 1'b1;
            enc_i <= 1'b1;
            settle();
            chk("mode", mode, mode_exp(k));
            chk("enc_pin", {encp.oe, encp.o}, 2'b10);
            for (int i = 0; i < 4 && k != 2; i++) begin
                r = rnd();
                bus(1'b1, PIO_OFF_FDC, {28'h0, r[3], 3'h0});
                done <= r[4];
                xrdy <= r[5];
                settle();
                chk("irq6", {p6.oe, p6.o}, {1'b1, (k == 1 || r[3]) && (r[4] || r[5])});
            end
        end
        done <= 1'b0;
        xrdy <= 1'b0;
        for (int i = 0; i < 40; i++) begin
            r = rnd();
            r[14:13] = r[6:5] ^ 2'b01;
            bus(1'b1, PIO_OFF_SER0, {25'h0, r[6:0]});
            bus(1'b1, PIO_OFF_SER1, {25'h0, r[14:8]});
            cond <= r[22:15];
            svc <= r[24:23];
            settle();
            bus(1'b0, PIO_OFF_SER0, 32'h0);
            chk("ser_rd", q, {25'h0, r[6:0]});
            chk("irq3", {p3.oe, p3.oe & p3.o},
                r[5] ? ser_exp(r[6:0], r[18:15]) : ser_exp(r[14:8], r[22:19]));
            chk("irq4", {p4.oe, p4.oe & p4.o},
                r[5] ? ser_exp(r[14:8], r[22:19]) : ser_exp(r[6:0], r[18:15]));
        end
        bus(1'b1, PIO_OFF_SER1, 32'h0);
        bus(1'b1, PIO_OFF_SER0, 32'h1F);
        cond <= 8'h11;
        settle();
        chk("ser_on", {p3.oe, p4.oe, p4.o, lvl[4]}, 4'h7);
        bus(1'b1, PIO_OFF_SER0, 32'h10);
        settle();
        chk("ser_dis", {p3.oe, p4.oe, p4.o, lvl[4]}, 4'h4);
        mr <= 1'b1;
        settle();
        mr <= 1'b0;
        settle();
        bus(1'b0, PIO_OFF_SER1, 32'h0);
        chk("mr_reg", q, 32'h0);
        chk("mr_oe", {p3.oe, p4.oe}, 2'b00);
        for (int i = 0; i < 24; i++) begin
            r = rnd();
            bus(1'b1, PIO_OFF_PAR, {24'h0, r[7:4], 4'h0});
            ack <= r[8];
            settle();
            chk("par_en", p5.oe | p7.oe, r[4] & r[5] & ~(r[6] & r[7]));
            if (r[4] & r[5] & ~(r[6] & r[7]))
                chk("par_lvl", (p5.oe & p5.o) | (p7.oe & p7.o), r[8]);
            chk("par_dir", d5 | d7, r[6] & r[7]);
        end
        bus(1'b1, 4'h2, 32'hFF);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        end_of_test();
    end
endmodule
